/* design/clock_switchover_defs.svh */
// timing counts and pin positions for the clock switchover block
`ifndef CLOCK_SWITCHOVER_DEFS_SVH
`define CLOCK_SWITCHOVER_DEFS_SVH
`define INIT_CYCLES 16
`define PARK_EDGES 8
`define SWITCH_MAX_EDGES 17
`define PIN_A_P 0
`define PIN_A_N 1
`define PIN_B_P 2
`define PIN_B_N 3
`define PIN_SEL 4
`define PIN_SEL_DRIVEN 5
`define PIN_INIT_TIED 6
`define PIN_COUNT 7
`endif

/* design/clock_switchover_pkg.sv */
// types shared by the clock switchover modules
package clock_switchover_pkg;
	typedef enum logic [1:0] {ST_RUN, ST_PARK, ST_WAIT_LOW, ST_WAIT_HIGH} sw_state_type;
endpackage

/* design/suppress_if.sv */
// link between the switchover top and its runt suppressor
`timescale 1ns/100ps
interface suppress_if;
	logic src_a;
	logic src_b;
	logic sel;
	logic run;
	logic out;
	logic busy;
	modport top (output src_a, output src_b, output sel, output run, input out, input busy);
	modport sup (input src_a, input src_b, input sel, input run, output out, output busy);
endinterface

/* design/runt_suppressor.sv */
// runt suppressor: parks the output low across a change of source
`timescale 1ns/100ps
`include "clock_switchover_defs.svh"
module runt_suppressor (
	input wire logic clk_i,
	input wire logic srst_i,
	suppress_if.sup rs
);
	clock_switchover_pkg::sw_state_type state_ff;
	logic cur_ff;
	logic out_ff;
	logic prev_a_ff;
	logic prev_b_ff;
	logic [4:0] edges_ff;
	logic old_lvl;
	logic new_lvl;
	logic new_prev;
	logic new_rise;
	logic new_fall;

	// level of the outgoing source, level and edges of the incoming source
	assign old_lvl = cur_ff ? rs.src_b : rs.src_a;
	assign new_lvl = rs.sel ? rs.src_b : rs.src_a;
	assign new_prev = rs.sel ? prev_b_ff : prev_a_ff;
	assign new_rise = new_lvl & ~new_prev;
	assign new_fall = ~new_lvl & new_prev;
	assign rs.out = out_ff;
	assign rs.busy = (state_ff != clock_switchover_pkg::ST_RUN);

	// history for edge detection
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			prev_a_ff <= 1'b0;
			prev_b_ff <= 1'b0;
		end
		else
		begin
			prev_a_ff <= rs.src_a;
			prev_b_ff <= rs.src_b;
		end
	end

	// incoming rising edges since the switch began, saturating
	always_ff @(posedge clk_i)
	begin
		if (srst_i || !rs.busy)
			edges_ff <= 5'h00;
		else if (new_rise && edges_ff != 5'h1f)
			edges_ff <= edges_ff + 5'h01;
	end

	// switchover sequencer
	always_ff @(posedge clk_i)
	begin
		if (srst_i || !rs.run)
		begin
			state_ff <= clock_switchover_pkg::ST_RUN;
			cur_ff <= rs.sel;
			out_ff <= 1'b0;
		end
		else
		begin
			case (state_ff)
				clock_switchover_pkg::ST_RUN:
				begin
					out_ff <= old_lvl;
					if (rs.sel != cur_ff)
						state_ff <= clock_switchover_pkg::ST_PARK;
				end
				clock_switchover_pkg::ST_PARK:
				begin
					// park after old cycle completes
					// a dead old source is abandoned after a bounded wait
					if (!old_lvl || edges_ff >= 5'(`PARK_EDGES))
					begin
						out_ff <= 1'b0;
						cur_ff <= rs.sel;
						state_ff <= clock_switchover_pkg::ST_WAIT_LOW;
					end
					else
						out_ff <= old_lvl;
				end
				clock_switchover_pkg::ST_WAIT_LOW:
				begin
					// output held low, no short phase
					out_ff <= 1'b0;
					cur_ff <= rs.sel;
					if (new_fall && rs.sel == cur_ff)
						state_ff <= clock_switchover_pkg::ST_WAIT_HIGH;
				end
				clock_switchover_pkg::ST_WAIT_HIGH:
				begin
					// release only after full low phase
					if (rs.sel != cur_ff)
					begin
						cur_ff <= rs.sel;
						state_ff <= clock_switchover_pkg::ST_WAIT_LOW;
						out_ff <= 1'b0;
					end
					else if (new_rise)
					begin
						out_ff <= 1'b1;
						state_ff <= clock_switchover_pkg::ST_RUN;
					end
					else
						out_ff <= 1'b0;
				end
				default:
				begin
					state_ff <= clock_switchover_pkg::ST_RUN;
					out_ff <= 1'b0;
				end
			endcase
		end
	end

	chk_switch_bound: assert property (@(posedge clk_i) disable iff (srst_i)
		rs.busy |-> edges_ff <= 5'(`SWITCH_MAX_EDGES))
		else $error("switchover took too many input cycles");

	// parking happens only on a low old level or a dead old source
	chk_park_low: assert property (@(posedge clk_i) disable iff (srst_i || !rs.run)
		(state_ff == clock_switchover_pkg::ST_PARK) ##1 (state_ff == clock_switchover_pkg::ST_WAIT_LOW)
		|-> ($past(!old_lvl) || $past(edges_ff) >= 5'(`PARK_EDGES)) && !out_ff)
		else $error("output parked outside a low phase");

	// output rises after switching only on an incoming rising edge
	chk_no_runt: assert property (@(posedge clk_i) disable iff (srst_i || !rs.run)
		(state_ff == clock_switchover_pkg::ST_WAIT_HIGH) ##1 $rose(out_ff)
		|-> $past(new_rise))
		else $error("output released outside an incoming rising edge");
endmodule // runt_suppressor

/* design/clock_switchover_top.sv */
// two-to-one clock multiplexer with runt suppression and two output pairs
`timescale 1ns/100ps
`include "clock_switchover_defs.svh"
module clock_switchover_top (
	input wire logic MCLK_I,
	input wire logic SRST_I,
	input wire logic CLK_A_P_I,
	input wire logic CLK_A_N_I,
	input wire logic CLK_B_P_I,
	input wire logic CLK_B_N_I,
	input wire logic SEL_I,
	input wire logic SEL_DRIVEN_I,
	input wire logic INIT_PIN_TIED_I,
	output logic OUT_A_P_O,
	output logic OUT_A_N_O,
	output logic OUT_B_P_O,
	output logic OUT_B_N_O
);
	logic [`PIN_COUNT-1:0] pins;
	logic [`PIN_COUNT-1:0] meta_ff;
	logic [`PIN_COUNT-1:0] sync_ff;
	logic [1:0] clean_ff;
	logic [4:0] init_cnt_ff;
	logic init_done;
	logic sel_eff;
	logic bypass;
	logic nxt_out;
	logic out_ff;
	suppress_if rs ();

	// input differential pairs reduce to one level if the pair is live
	function automatic logic pair_dead(input logic p, input logic n);
		pair_dead = (p == n);
	endfunction

	// every pin is asynchronous to the block clock
	assign pins = {INIT_PIN_TIED_I, SEL_DRIVEN_I, SEL_I, CLK_B_N_I, CLK_B_P_I, CLK_A_N_I, CLK_A_P_I};

	// two-stage synchronisers; only sync_ff is read by logic
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= pins;
			sync_ff <= meta_ff;
		end
	end

	// per-input dead guard: a collapsed pair keeps its last level
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_guard
			always_ff @(posedge MCLK_I)
			begin
				if (SRST_I)
					clean_ff[i] <= 1'b0;
				else if (!pair_dead(sync_ff[2*i], sync_ff[2*i+1]))
					clean_ff[i] <= sync_ff[2*i];
			end
			chk_dead_hold: assert property (@(posedge MCLK_I) disable iff (SRST_I)
				pair_dead(sync_ff[2*i], sync_ff[2*i+1]) |=> $stable(clean_ff[i]))
				else $error("dead input changed the guarded level");
		end
	endgenerate

	assign sel_eff = sync_ff[`PIN_SEL] | ~sync_ff[`PIN_SEL_DRIVEN];
	assign bypass = sync_ff[`PIN_INIT_TIED];

	// power-on settle time before the suppressor may switch
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
			init_cnt_ff <= 5'h00;
		else if (!init_done)
			init_cnt_ff <= init_cnt_ff + 5'h01;
	end
	assign init_done = (init_cnt_ff == 5'(`INIT_CYCLES));

	// feed the suppressor
	assign rs.src_a = clean_ff[0];
	assign rs.src_b = clean_ff[1];
	assign rs.sel = sel_eff;
	assign rs.run = init_done & ~bypass;

	runt_suppressor u_sup (
		.clk_i(MCLK_I),
		.srst_i(SRST_I),
		.rs(rs)
	);

	// output source: bypass is glitchy by design, the user asked for it
	always_comb
	begin
		if (bypass)
			nxt_out = sel_eff ? clean_ff[1] : clean_ff[0];
		else if (init_done)
			nxt_out = rs.out;
		else
			nxt_out = 1'b0;
	end

	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
			out_ff <= 1'b0;
		else
			out_ff <= nxt_out;
	end

	// one flop fans out to both pairs
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
		begin
			OUT_A_P_O <= 1'b0;
			OUT_A_N_O <= 1'b1;
			OUT_B_P_O <= 1'b0;
			OUT_B_N_O <= 1'b1;
		end
		else
		begin
			OUT_A_P_O <= out_ff;
			OUT_A_N_O <= ~out_ff;
			OUT_B_P_O <= out_ff;
			OUT_B_N_O <= ~out_ff;
		end
	end

	// watch for a dead selected pair while nothing else may move the output
	// the watch restarts on any select or strap change, since those move it legally
	logic sel_pair_dead;
	logic quiet_cond;
	logic prev_sel_ff;
	logic prev_byp_ff;
	logic [3:0] quiet_cnt_ff;

	assign sel_pair_dead = sel_eff ? pair_dead(sync_ff[`PIN_B_P], sync_ff[`PIN_B_N])
		: pair_dead(sync_ff[`PIN_A_P], sync_ff[`PIN_A_N]);
	assign quiet_cond = sel_pair_dead && (sel_eff == prev_sel_ff) && (bypass == prev_byp_ff)
		&& (bypass || (init_done && !rs.busy));

	// previous select and strap, kept only for the watch
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I)
		begin
			prev_sel_ff <= 1'b0;
			prev_byp_ff <= 1'b0;
		end
		else
		begin
			prev_sel_ff <= sel_eff;
			prev_byp_ff <= bypass;
		end
	end

	// consecutive quiet cycles, saturating so it never wraps back to zero
	always_ff @(posedge MCLK_I)
	begin
		if (SRST_I || !quiet_cond)
			quiet_cnt_ff <= 4'h0;
		else if (quiet_cnt_ff != 4'hf)
			quiet_cnt_ff <= quiet_cnt_ff + 4'h1;
	end

	// output pins frozen on dead input
	chk_dead_out_still: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		quiet_cnt_ff >= 4'h4 |-> $stable(OUT_A_P_O) && $stable(OUT_B_P_O))
		else $error("output moved while the selected pair was dead");

	chk_settle_len: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		$rose(init_done) |-> $past(init_cnt_ff) == 5'(`INIT_CYCLES - 1))
		else $error("settle period ended at the wrong count");

	chk_sel_b_path: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		(bypass && sel_eff) ##2 bypass |-> OUT_A_P_O == $past(clean_ff[1], 2))
		else $error("select high did not pass input B");

	chk_pairs_equal: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		OUT_A_P_O == OUT_B_P_O && OUT_A_N_O == ~OUT_A_P_O && OUT_B_N_O == ~OUT_B_P_O)
		else $error("output pairs disagree");

	chk_bypass_path: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		bypass ##1 bypass |=> OUT_A_P_O == ($past(sel_eff, 2) ? $past(clean_ff[1], 2)
			: $past(clean_ff[0], 2)))
		else $error("plain multiplexer path wrong");

	chk_sel_a_path: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		(bypass && !sel_eff) ##2 bypass |-> OUT_B_P_O == $past(clean_ff[0], 2))
		else $error("select low did not pass input A");

	chk_open_sel: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		!sync_ff[`PIN_SEL_DRIVEN] |-> rs.sel)
		else $error("floating select did not read high");

	chk_init_low: assert property (@(posedge MCLK_I) disable iff (SRST_I)
		(!init_done && !bypass) |=> ##1 !OUT_A_P_O)
		else $error("output moved before settle ended");
endmodule // clock_switchover_top

/* tb/clk_source_model.sv */
// behavioural clock source pair feeding one input of the switchover
`timescale 1ns/100ps
module clk_source_model #(parameter realtime HALF = 160.0) (
	input wire logic run_i,
	input wire logic dead_i,
	output logic p_o,
	output logic n_o
);
	logic ph = 1'b0;
	// offset keeps source edges away from both block clock edges
	initial
	begin
		#10;
		forever #(HALF) if (run_i) ph = ~ph;
	end
	assign p_o = ph;
	assign n_o = dead_i ? ph : ~ph;
endmodule // clk_source_model

/* tb/clock_switchover_top_tb.sv */
// self-checking bench for the clock switchover block
`timescale 1ns/100ps
module clock_switchover_top_tb;
	logic MCLK_I = 1'b0;
	logic SRST_I = 1'b1;
	logic SEL_I = 1'b0;
	logic SEL_DRIVEN_I = 1'b1;
	logic INIT_PIN_TIED_I = 1'b0;
	logic run_a = 1'b1;
	logic run_b = 1'b1;
	logic dead_a = 1'b0;
	logic a_p, a_n, b_p, b_n, qa_p, qa_n, qb_p, qb_n;
	int error_cnt = 0;
	int n_tests = 0;
	always #20 MCLK_I = ~MCLK_I;
	clk_source_model #(.HALF(160.0)) src_a (.run_i(run_a), .dead_i(dead_a), .p_o(a_p), .n_o(a_n));
	clk_source_model #(.HALF(240.0)) src_b (.run_i(run_b), .dead_i(1'b0), .p_o(b_p), .n_o(b_n));
	clock_switchover_top dut (.MCLK_I(MCLK_I), .SRST_I(SRST_I), .CLK_A_P_I(a_p),
		.CLK_A_N_I(a_n), .CLK_B_P_I(b_p), .CLK_B_N_I(b_n), .SEL_I(SEL_I),
		.SEL_DRIVEN_I(SEL_DRIVEN_I), .INIT_PIN_TIED_I(INIT_PIN_TIED_I), .OUT_A_P_O(qa_p),
		.OUT_A_N_O(qa_n), .OUT_B_P_O(qb_p), .OUT_B_N_O(qb_n));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one falling edge, then complementary and identical pairs
	task automatic tick();
		@(negedge MCLK_I);
		check("pairs", {qb_p, qb_n, qa_n}, {qa_p, ~qa_p, ~qa_p});
	endtask
	task automatic test_init();
		repeat (12) tick();
		check("reset level", qa_p, 1'b0);
		SRST_I = 1'b0;
		repeat (18)
		begin
			tick();
			check("settle park", qa_p, 1'b0);
		end
		$display("test init done");
	endtask
	// widths are 4 cycles for source a and 6 for source b
	task automatic test_switch();
		int len, first, done_at;
		logic last;
		len = 0;
		first = 1;
		done_at = 0;
		repeat (60) tick();
		SEL_I = 1'b1;
		last = qa_p;
		for (int i = 0; i < 300; i++)
		begin
			tick();
			if (qa_p === last)
				len++;
			else
			begin
				if (!first) check("phase width", len >= 4, 1'b1);
				if (done_at != 0) check("new width", len, 6);
				else if (!first && len == 6) done_at = i;
				first = 0;
				len = 1;
				last = qa_p;
			end
		end
		check("switch time", done_at > 0 && done_at <= 17 * 12 + 12, 1'b1);
		$display("test switch done");
	endtask
	task automatic test_dead();
		logic last;
		SEL_I = 1'b0;
		repeat (300) tick();
		dead_a = 1'b1;
		repeat (10) tick();
		last = qa_p;
		repeat (40)
		begin
			tick();
			check("dead hold", qa_p, last);
		end
		dead_a = 1'b0;
		$display("test dead done");
	endtask
	// stopped sources: a low, b high; no b edge ever arrives
	task automatic test_bypass();
		INIT_PIN_TIED_I = 1'b1;
		for (int i = 0; i < 20; i++)
		begin
			tick();
			if (a_p === 1'b0) run_a = 1'b0;
			if (b_p === 1'b1) run_b = 1'b0;
		end
		repeat (8) tick();
		check("sel a", qa_p, 1'b0);
		SEL_I = 1'b1;
		repeat (8) tick();
		check("sel b plain", qa_p, 1'b1);
		SEL_I = 1'b0;
		SEL_DRIVEN_I = 1'b0;
		repeat (8) tick();
		check("sel floating", qa_p, 1'b1);
		$display("test bypass done");
	endtask
	initial
	begin
		#2000000;
		check("timeout", 1'b1, 1'b0);
		print_verdict();
	end
	initial
	begin
		test_init();
		test_switch();
		test_dead();
		test_bypass();
		print_verdict();
	end
endmodule // clock_switchover_top_tb
